//--- pkg/rls_pkg.sv
// Package for the remote I/O link status supervisor.
// Assumes a single pclk domain at 20 MHz and an APB register port.
package rls_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYC        = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned TMO_MIN_MS      = 400;
  localparam int unsigned TMO_MAX_MS      = 25500;
  localparam int unsigned TMO_DEF_MS      = 1000;
  localparam int unsigned PER_MIN_MS      = 100;
  localparam int unsigned PER_MAX_MS      = 25500;
  localparam int unsigned PER_DEF_MS      = 1000;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_TIMEOUT  = 8'h08;
  localparam logic [7:0] OFS_PERIOD   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_OUTDEF   = 8'h18;
  localparam logic [7:0] OFS_NODE     = 8'h1c;
  localparam logic [7:0] OFS_INPUTS   = 8'h20;
  // ==========================================================
  // Status word fields
  localparam int BIT_ABSENT    = 1;
  localparam int BIT_AWAIT     = 2;
  localparam int BIT_CLASS     = 3;
  localparam int BIT_FWOLD     = 4;
  localparam int BIT_LIFE      = 9;
  localparam int BIT_PUP       = 10;
  localparam int BIT_REFRESH   = 16;
  localparam logic [16:0] STATUS_RST = 17'h00000;
  // Control fields.
  localparam int CTRL_PERIODIC = 0;
  localparam int CTRL_INPOL    = 1;
  // Interrupt event bits.
  localparam int EV_ABSENT  = 0;
  localparam int EV_LIFE    = 1;
  localparam int EV_PUP     = 2;
  localparam int EV_REFDONE = 3;
  localparam int EV_TMO     = 4;
  localparam int EV_W       = 5;
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'hfd;

  typedef struct packed {
    logic       present;
    logic       configured;
    logic       class_ok;
    logic       fw_ok;
    logic       life_lost;
    logic       pup_reconf;
    logic       frame_rx;
    logic [7:0] inputs;
  } rls_link_t;

  typedef struct packed {
    logic [7:0] hold;
    logic [7:0] override;
  } rls_outdef_t;
endpackage

//--- src/rls_ms_timer.sv
// Millisecond countdown timer with a programmable reload in milliseconds.
// Assumes a one-cycle tick input of one millisecond.
`timescale 1ns/10ps
module rls_ms_timer #(
  parameter int unsigned MAX_MS = 25500
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        en,
  input  wire logic        ms_tick,
  input  wire logic        restart,
  input  wire logic [15:0] reload_ms,
  output logic             expired
);
  import rls_pkg::*;
  logic [15:0] cnt_r;

  initial begin
    if (MAX_MS > 65535) $error("rls_ms_timer: MAX_MS too large.");
  end

  // ==========================================================
  // Counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 16'h0000;
      expired <= 1'b0;
    end else if (en) begin
      expired <= 1'b0;
      if (restart) begin
        cnt_r <= reload_ms;
      end else if (ms_tick && cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          expired <= 1'b1;
        end
      end
    end
  end
endmodule

//--- src/rls_apb_regs.sv
// APB slave decode for the supervisor register file.
// Assumes zero-wait answers; the owner supplies read data.
`timescale 1ns/10ps
module rls_apb_regs (
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  output logic            pready,
  output logic            pslverr,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic            hit
);
  import rls_pkg::*;
  // ==========================================================
  // Decode
  always_comb begin
    hit = (paddr[1:0] == 2'h0) && (paddr <= OFS_INPUTS);
    pready  = psel && penable;
    pslverr = psel && penable && !hit;
    wr_stb  = psel && penable && pwrite && hit;
    rd_stb  = psel && penable && !pwrite && hit;
  end
endmodule

//--- src/rls_supervisor.sv
// Remote I/O link status supervisor: status word, timeouts, refresh, output defaults.
// Assumes a link engine outside that reports module condition and sends frames.
`timescale 1ns/10ps
module rls_supervisor #(
  parameter int unsigned TICK_CYCLES = rls_pkg::TICK_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire rls_pkg::rls_link_t  link_in,
  input  wire logic                send_done,
  output logic                     send_req,
  output logic [7:0]               out_data,
  output logic                     out_stopped,
  output logic                     irq
);
  import rls_pkg::*;

  logic        wr_stb;
  logic        rd_stb;
  logic        hit;
  logic [16:0] status_r;
  logic [1:0]  ctrl_r;
  logic [7:0]  tmo_r;
  logic [7:0]  per_r;
  logic [EV_W-1:0] ev_stat_r;
  logic [EV_W-1:0] ev_mask_r;
  rls_outdef_t outdef_r;
  logic [7:0]  node_r;
  logic [7:0]  outs_r;
  logic [7:0]  last_in_r;
  logic [15:0] tick_cnt_r;
  logic        ms_tick;
  logic        tmo_exp;
  logic        per_exp;
  logic        tmo_hit_r;
  logic        absent_prev_r;
  logic        input_send_r;
  logic        node_ok;
  logic [EV_W-1:0] ev_now;
  logic        tmo_wr_r;
  logic        per_wr_r;
  logic        status_wr;

  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) $error("rls_supervisor: bad TICK_CYCLES.");
  end

  function automatic logic [15:0] tenths_to_ms(input logic [7:0] tenths, input int unsigned min_ms);
    logic [15:0] ms;
    ms = 16'(tenths) * 16'd100;
    if (ms < 16'(min_ms)) begin
      ms = 16'(min_ms);
    end
    return ms;
  endfunction

  // ==========================================================
  // Bus slave
  rls_apb_regs u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .hit     (hit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && rd_stb) begin
      // Captured at the access edge, so software sees the word from the next cycle on.
      case (paddr)
        OFS_STATUS:   prdata <= {15'h0000, status_r};
        OFS_CTRL:     prdata <= {30'h00000000, ctrl_r};
        OFS_TIMEOUT:  prdata <= {24'h000000, tmo_r};
        OFS_PERIOD:   prdata <= {24'h000000, per_r};
        OFS_IRQ_STAT: prdata <= {27'h0000000, ev_stat_r};
        OFS_IRQ_MASK: prdata <= {27'h0000000, ev_mask_r};
        OFS_OUTDEF:   prdata <= {16'h0000, outdef_r};
        OFS_NODE:     prdata <= {23'h000000, node_ok, node_r};
        OFS_INPUTS:   prdata <= {16'h0000, outs_r, last_in_r};
        default:      prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= 2'h0;
      tmo_r     <= 8'(TMO_DEF_MS / 100);
      per_r     <= 8'(PER_DEF_MS / 100);
      ev_mask_r <= '0;
      outdef_r  <= '0;
      node_r    <= NODE_MIN;
      outs_r    <= 8'h00;
    end else if (clk_en && wr_stb) begin
      case (paddr)
        OFS_CTRL:     ctrl_r    <= pwdata[1:0];
        OFS_TIMEOUT:  tmo_r     <= pwdata[7:0];
        OFS_PERIOD:   per_r     <= pwdata[7:0];
        OFS_IRQ_MASK: ev_mask_r <= pwdata[EV_W-1:0];
        OFS_OUTDEF:   outdef_r  <= pwdata[15:0];
        OFS_NODE:     node_r    <= pwdata[7:0];
        OFS_INPUTS:   outs_r    <= pwdata[15:8];
        default:      ;
      endcase
    end
  end

  // Identifiers outside the legal range are flagged so software sees its mistake.
  assign node_ok = (node_r >= NODE_MIN) && (node_r <= NODE_MAX);

  // Shared decode of a status word write, used by the checks.
  assign status_wr = wr_stb && (paddr == OFS_STATUS);

  // ==========================================================
  // Timebase and timers
  assign ms_tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      tick_cnt_r <= ms_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    end
  end

  // Restarting on the write edge itself would load the previous reload value, so the restart follows a cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_wr_r <= 1'b0;
      per_wr_r <= 1'b0;
    end else if (clk_en) begin
      tmo_wr_r <= wr_stb && (paddr == OFS_TIMEOUT);
      per_wr_r <= wr_stb && ((paddr == OFS_PERIOD) || (paddr == OFS_CTRL));
    end
  end

  rls_ms_timer #(.MAX_MS(TMO_MAX_MS)) u_tmo (
    .pclk      (pclk),
    .presetn   (presetn),
    .en        (clk_en),
    .ms_tick   (ms_tick),
    .restart   (link_in.frame_rx || tmo_hit_r || tmo_wr_r),
    .reload_ms (tenths_to_ms(tmo_r, TMO_MIN_MS)),
    .expired   (tmo_exp)
  );

  rls_ms_timer #(.MAX_MS(PER_MAX_MS)) u_per (
    .pclk      (pclk),
    .presetn   (presetn),
    .en        (clk_en),
    .ms_tick   (ms_tick),
    .restart   (per_exp || per_wr_r || (tick_cnt_r == 16'h0000 && input_send_r)),
    .reload_ms (tenths_to_ms(per_r, PER_MIN_MS)),
    .expired   (per_exp)
  );

  // ==========================================================
  // Status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r  <= STATUS_RST;
      tmo_hit_r <= 1'b0;
    end else if (clk_en) begin
      tmo_hit_r <= tmo_exp;
      status_r[BIT_ABSENT] <= !link_in.present || tmo_exp;
      status_r[BIT_AWAIT]  <= link_in.present && !link_in.configured;
      status_r[BIT_CLASS]  <= link_in.present && !link_in.class_ok;
      status_r[BIT_FWOLD]  <= link_in.present && !link_in.fw_ok;
      status_r[0]     <= 1'b0;
      status_r[8:5]   <= 4'h0;
      status_r[15:11] <= 5'h00;
      // A write of one clears a sticky bit, but a new event in that cycle wins.
      if (link_in.life_lost || tmo_exp) begin
        status_r[BIT_LIFE] <= 1'b1;
      end else if (wr_stb && paddr == OFS_STATUS && pwdata[BIT_LIFE]) begin
        status_r[BIT_LIFE] <= 1'b0;
      end
      if (link_in.pup_reconf) begin
        status_r[BIT_PUP] <= 1'b1;
      end else if (wr_stb && paddr == OFS_STATUS && pwdata[BIT_PUP]) begin
        status_r[BIT_PUP] <= 1'b0;
      end
      if (wr_stb && paddr == OFS_STATUS && pwdata[BIT_REFRESH]) begin
        status_r[BIT_REFRESH] <= 1'b1;
      end else if (send_done) begin
        status_r[BIT_REFRESH] <= 1'b0;
      end
    end
  end

  // Refresh is requested as a level until the link engine reports all outputs sent.
  assign send_req = status_r[BIT_REFRESH];

  // ==========================================================
  // Input update method
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_in_r    <= 8'h00;
      input_send_r <= 1'b0;
    end else if (clk_en) begin
      last_in_r <= link_in.inputs;
      if (ctrl_r[CTRL_PERIODIC]) begin
        input_send_r <= per_exp;
      end else begin
        input_send_r <= (link_in.inputs != last_in_r);
      end
    end
  end

  // ==========================================================
  // Output defaults on communication loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_stopped <= 1'b0;
      out_data    <= 8'h00;
    end else if (clk_en) begin
      if (tmo_exp || link_in.life_lost) begin
        out_stopped <= 1'b1;
      end else if (link_in.frame_rx) begin
        out_stopped <= 1'b0;
      end
      if (out_stopped) begin
        // Held bits keep their last value; the rest take the override pattern.
        out_data <= (out_data & outdef_r.hold) | (outdef_r.override & ~outdef_r.hold);
      end else begin
        out_data <= outs_r;
      end
    end
  end

  // ==========================================================
  // Interrupts
  always_comb begin
    ev_now = '0;
    ev_now[EV_ABSENT]  = status_r[BIT_ABSENT] && !absent_prev_r;
    ev_now[EV_LIFE]    = link_in.life_lost;
    ev_now[EV_PUP]     = link_in.pup_reconf;
    ev_now[EV_REFDONE] = send_done && status_r[BIT_REFRESH];
    ev_now[EV_TMO]     = tmo_exp;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_r     <= '0;
      absent_prev_r <= 1'b0;
    end else if (clk_en) begin
      absent_prev_r <= status_r[BIT_ABSENT];
      if (wr_stb && paddr == OFS_IRQ_STAT) begin
        ev_stat_r <= (ev_stat_r & ~pwdata[EV_W-1:0]) | ev_now;
      end else begin
        ev_stat_r <= ev_stat_r | ev_now;
      end
    end
  end

  assign irq = |(ev_stat_r & ev_mask_r);

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  absent_set_a: assert property (clk_en && !link_in.present |=> status_r[BIT_ABSENT])
    else $error("Absent bit not set.");
  await_set_a: assert property (clk_en && link_in.present && !link_in.configured |=> status_r[BIT_AWAIT])
    else $error("Await bit not set.");
  class_set_a: assert property (clk_en && link_in.present && !link_in.class_ok |=> status_r[BIT_CLASS])
    else $error("Class bit not set.");
  fw_set_a: assert property (clk_en && link_in.present && !link_in.fw_ok |=> status_r[BIT_FWOLD])
    else $error("Firmware bit not set.");
  life_sticky_a: assert property (status_r[BIT_LIFE] && !(wr_stb && paddr == OFS_STATUS) |=> status_r[BIT_LIFE])
    else $error("Life bit dropped without a write.");
  pup_sticky_a: assert property (status_r[BIT_PUP] && !(wr_stb && paddr == OFS_STATUS) |=> status_r[BIT_PUP])
    else $error("Reconfigure bit dropped without a write.");
  refresh_hold_a: assert property (send_req && !send_done |=> send_req)
    else $error("Refresh request dropped early.");
  zero_bits_a: assert property (##1 status_r[0] == 1'b0 && status_r[8:5] == 4'h0 && status_r[15:11] == 5'h00)
    else $error("Unused status bits not zero.");
  stop_out_a: assert property (clk_en && out_stopped |=> out_data == (($past(out_data) & outdef_r.hold)
      | (outdef_r.override & ~outdef_r.hold)))
    else $error("Stopped output not default.");
  tmo_stop_a: assert property (clk_en && tmo_exp |=> out_stopped && status_r[BIT_LIFE])
    else $error("Timeout did not stop outputs.");

  // ==========================================================
  // Clearing and sending checks
  // The set checks alone would still hold if a bit were stuck high, so each has a clearing partner except the class and firmware checks.
  absent_clr_a: assert property (clk_en && link_in.present && !tmo_exp |=> !status_r[BIT_ABSENT])
    else $error("Absent bit set while module answers.");
  await_clr_a: assert property (clk_en && link_in.configured |=> !status_r[BIT_AWAIT])
    else $error("Await bit set after configuration.");
  life_clear_a: assert property (clk_en && status_wr && pwdata[BIT_LIFE] && !link_in.life_lost && !tmo_exp
      |=> !status_r[BIT_LIFE])
    else $error("Life bit not cleared by write.");
  pup_clear_a: assert property (clk_en && status_wr && pwdata[BIT_PUP] && !link_in.pup_reconf
      |=> !status_r[BIT_PUP])
    else $error("Reconfigure bit not cleared by write.");
  refresh_set_a: assert property (clk_en && status_wr && pwdata[BIT_REFRESH] |=> send_req)
    else $error("Refresh request not raised.");
  refresh_clr_a: assert property (clk_en && send_done && !(status_wr && pwdata[BIT_REFRESH])
      |=> !send_req)
    else $error("Refresh request not cleared when done.");
  cos_send_a: assert property (clk_en && !ctrl_r[CTRL_PERIODIC] && (link_in.inputs != last_in_r)
      |=> input_send_r)
    else $error("Input change not sent.");
  per_send_a: assert property (clk_en && ctrl_r[CTRL_PERIODIC] && per_exp |=> input_send_r)
    else $error("Periodic input update not sent.");
  ev_sticky_a: assert property (clk_en && |ev_now |=> (ev_stat_r & $past(ev_now)) == $past(ev_now))
    else $error("Event not latched.");
  out_live_a: assert property (clk_en && !out_stopped |=> out_data == $past(outs_r))
    else $error("Running output not taken from register.");

  refresh_c: cover property (send_req ##[1:20] !send_req);
  life_c:    cover property (status_r[BIT_LIFE]);
  irq_c:     cover property (irq);
  per_c:     cover property (ctrl_r[CTRL_PERIODIC] && input_send_r);
  resume_c:  cover property (out_stopped ##1 !out_stopped);
endmodule

//--- verification/rls_link_model.sv
// Behavioural model of the remote I/O module on the far side of the link engine.
// Assumes the bench commands faults, events, frame traffic and answer speed.
`timescale 1ns/10ps
module rls_link_model (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [3:0]   fault,
  input  wire logic         ev_life,
  input  wire logic         ev_pup,
  input  wire logic         frames_on,
  input  wire logic         slow,
  input  wire logic [7:0]   pins,
  input  wire logic         send_req,
  output rls_pkg::rls_link_t link,
  output logic              send_done
);
  import rls_pkg::*;
  logic [5:0] fcnt_r;
  logic [7:0] last_r;
  logic [4:0] dly_r;
  // ==========================================================
  // Condition levels and frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_r <= 6'h00;
      last_r <= 8'h00;
      link   <= '0;
    end else begin
      fcnt_r           <= fcnt_r + 6'h01;
      link.present     <= !fault[0];
      link.configured  <= !fault[1];
      link.class_ok    <= !fault[2];
      link.fw_ok       <= !fault[3];
      link.life_lost   <= ev_life;
      link.pup_reconf  <= ev_pup;
      link.inputs      <= pins;
      last_r           <= pins;
      // A frame also goes out on any input change, not only on the beat.
      link.frame_rx    <= frames_on && (fcnt_r == 6'h00 || pins != last_r);
    end
  end
  // ==========================================================
  // Output send completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_r     <= 5'h00;
      send_done <= 1'b0;
    end else begin
      send_done <= 1'b0;
      if (!send_req) begin
        dly_r <= 5'h00;
      end else if (dly_r == (slow ? 5'h14 : 5'h01)) begin
        send_done <= 1'b1;
        dly_r     <= 5'h00;
      end else begin
        dly_r <= dly_r + 5'h01;
      end
    end
  end
endmodule

//--- verification/rls_supervisor_tb.sv
// Self-checking bench for the link status supervisor.
// Assumes the module model sits on the link side and APB is driven here.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
module rls_supervisor_tb;
  import rls_pkg::*;
  localparam int unsigned TK = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        send_req, send_done, out_stopped, irq, ev_life, ev_pup;
  logic        frames_on, slow, rd_pend, clk_en;
  logic [7:0]  paddr, out_data, pins, ov, pv, hv, dv;
  logic [3:0]  fault, f;
  logic [31:0] pwdata, prdata, rd_exp;
  logic [31:0] expq[$];
  logic [7:0]  ids[4] = '{8'h00, 8'h01, 8'hfd, 8'hfe};
  rls_link_t   link;
  int          failures, cmp_count, cyc, n;
  rls_supervisor #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_in(link), .send_done(send_done), .send_req(send_req), .out_data(out_data),
    .out_stopped(out_stopped), .irq(irq));
  rls_link_model peer (.pclk(pclk), .presetn(presetn), .fault(fault), .ev_life(ev_life), .ev_pup(ev_pup),
    .frames_on(frames_on), .slow(slow), .pins(pins), .send_req(send_req), .link(link), .send_done(send_done));
  // ==========================================================
  // Clock, read-data checker and run limit
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Read data is registered, so it is judged one edge after the access.
  always @(posedge pclk) begin
    cyc++;
    if (rd_pend) begin
      rd_exp = expq.pop_front();
      `CHK(prdata, rd_exp)
      rd_pend <= 1'b0;
    end
    if (cyc >= 20000) begin
      failures++;
      close_out();
    end
  end
  // ==========================================================
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic err = 1'b0);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    `CHK(pslverr, err)
    if (!w && !err) begin
      expq.push_back(e);
      rd_pend <= 1'b1;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic close_out();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    {psel, penable, pwrite, rd_pend, ev_life, ev_pup, slow} = '0;
    paddr = 8'h00; pwdata = 32'h0; fault = 4'h0; pins = 8'h00; frames_on = 1'b1;
    presetn = 1'b0; failures = 0; cmp_count = 0; cyc = 0; clk_en = 1'b1;
    void'($urandom(32'h115d));
    tick(12);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_STATUS, 0, 32'h0);
    apb(0, OFS_TIMEOUT, 0, 32'd10);
    apb(0, OFS_PERIOD, 0, 32'd10);
    apb(0, OFS_CTRL, 0, 32'h0);
    apb(1, OFS_CTRL, 32'h1, 0);
    apb(0, OFS_CTRL, 0, 32'h1);
    apb(1, OFS_PERIOD, 32'd1, 0);
    apb(0, OFS_PERIOD, 0, 32'd1);
    tick(420);
    apb(1, OFS_CTRL, 32'h0, 0);
    apb(0, 8'h24, 0, 0, 1'b1);
    apb(1, 8'h06, 32'h1, 0, 1'b1);
    $display("test reset_and_map done");
    for (int i = 0; i < 6; i++) begin
      f = (i < 4) ? 4'(4'h1 << i) : 4'($urandom);
      fault <= f;
      tick(3);
      apb(0, OFS_STATUS, 0, f[0] ? 32'h2 : {27'h0, f, 1'b0});
    end
    fault <= 4'h0;
    tick(3);
    apb(0, OFS_STATUS, 0, 32'h0);
    $display("test live_bits done");
    apb(1, OFS_IRQ_STAT, 32'h1f, 0);
    for (int i = 0; i < 3; i++) begin
      apb(1, OFS_IRQ_MASK, (i < 2) ? 32'h1f : 32'h0, 0);
      if (i == 1) ev_pup <= 1'b1; else ev_life <= 1'b1;
      tick(1);
      {ev_life, ev_pup} <= 2'b00;
      tick(4);
      `CHK(irq, i < 2)
      apb(0, OFS_STATUS, 0, 32'h1 << (9 + i % 2));
      apb(1, OFS_STATUS, 32'h0, 0);
      apb(0, OFS_STATUS, 0, 32'h1 << (9 + i % 2));
      apb(1, OFS_STATUS, 32'h1 << (9 + i % 2), 0);
      apb(0, OFS_STATUS, 0, 32'h0);
      apb(0, OFS_IRQ_STAT, 0, 32'h1 << (1 + i % 2));
      apb(1, OFS_IRQ_STAT, 32'h1f, 0);
      tick(1);
      `CHK(irq, 1'b0)
    end
    $display("test sticky_irq done");
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      apb(1, OFS_STATUS, 32'h10000, 0);
      `CHK(send_req, 1'b1)
      n = 0;
      while (send_req === 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
      `CHK(n >= i * 15 && n < 100, 1'b1)
      apb(0, OFS_STATUS, 0, 32'h0);
      apb(0, OFS_IRQ_STAT, 0, 32'h8);
      apb(1, OFS_IRQ_STAT, 32'h1f, 0);
    end
    $display("test refresh done");
    ov = $urandom;
    pv = $urandom;
    apb(1, OFS_INPUTS, {16'h0, ov, 8'h00}, 0);
    pins <= pv;
    tick(4);
    apb(0, OFS_INPUTS, 0, {16'h0, ov, pv});
    `CHK(out_data, ov)
    for (int i = 0; i < 4; i++) begin
      apb(1, OFS_NODE, {24'h0, ids[i]}, 0);
      apb(0, OFS_NODE, 0, {23'h0, ids[i] >= NODE_MIN && ids[i] <= NODE_MAX, ids[i]});
    end
    clk_en <= 1'b0;
    apb(1, OFS_NODE, 32'h55, 0);
    clk_en <= 1'b1;
    apb(0, OFS_NODE, 0, {23'h0, 1'b0, 8'hfe});
    $display("test io_and_node done");
    hv = $urandom;
    dv = $urandom;
    apb(1, OFS_OUTDEF, {16'h0, hv, dv}, 0);
    apb(1, OFS_TIMEOUT, 32'd4, 0);
    apb(0, OFS_TIMEOUT, 0, 32'd4);
    frames_on <= 1'b0;
    n = 0;
    while (out_stopped !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    `CHK(n > TMO_MIN_MS * TK - 100 && n < TMO_MIN_MS * TK + 100, 1'b1)
    tick(2);
    `CHK(out_data, (ov & hv) | (dv & ~hv))
    apb(0, OFS_STATUS, 0, 32'h200);
    frames_on <= 1'b1;
    tick(80);
    `CHK(out_stopped, 1'b0)
    $display("test timeout done");
    close_out();
  end
endmodule
